// ### design/gain_offset_register_bank.sv
`timescale 1ns/1ps
`include "gob_consts.svh"
// What this block does
// - Three offset codes, reset to mid-scale 80h
// - Colour select picks applied offset and gain
// - Offset broadcast write loads all three
// - Three gain codes, reset to zero
// - Gain equals 0.78 plus code*7.57/255
// - Gain broadcast write loads all three
module gain_offset_register_bank (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire gob_pkg::addr_t paddr,
   input wire gob_pkg::apb_data_t pwdata,
   output logic pready,
   output gob_pkg::apb_data_t prdata,
   output logic pslverr,
   input wire gob_pkg::colour_t colour_select,
   output gob_pkg::code_t offset_code_out,
   output gob_pkg::code_t gain_code_out,
   output gob_pkg::gain_milli_t gain_milli_out
);
   import gob_pkg::*;

   // Stored codes, one slot per colour
   code_t offset_ff [`GOB_NUM_COL];
   code_t gain_ff [`GOB_NUM_COL];

   // APB answer flops
   logic pready_ff;
   apb_data_t prdata_ff;
   logic pslverr_ff;

   // Applied channel values, registered
   code_t offset_out_ff;
   code_t gain_out_ff;
   gain_milli_t gain_milli_ff;

   // Marks the first cycle after reset release
   logic first_ff;

   // Shared code bus to the colour selector
   code_bus_if cb ();

   // Phase decode
   wire logic setup_phase = psel & ~penable; // Setup cycle
   wire logic access_fire = psel & penable & pready_ff; // Completing edge
   wire logic wr_fire = access_fire & pwrite; // Write takes effect
   wire code_t wr_byte = pwdata[`GOB_CODE_W-1:0]; // Low byte carries the code

   // Alignment check on the byte address
   wire logic addr_aligned = ((paddr & `GOB_ALIGN_MASK) == `GOB_ADDR_W'(0));

   // Broadcast location hits
   wire logic hit_off_all = addr_aligned & (paddr == `GOB_ADDR_OFF_ALL);
   wire logic hit_gain_all = addr_aligned & (paddr == `GOB_ADDR_GAIN_ALL);
   // Status location hit
   wire logic hit_status = addr_aligned & (paddr == `GOB_ADDR_STATUS);

   // Per-colour decode results
   logic [`GOB_NUM_COL-1:0] hit_off;
   logic [`GOB_NUM_COL-1:0] hit_gain;
   // Per-colour write loads
   logic [`GOB_NUM_COL-1:0] load_off;
   logic [`GOB_NUM_COL-1:0] load_gain;
   // Per-colour read contributions
   apb_data_t rd_off [`GOB_NUM_COL];
   apb_data_t rd_gain [`GOB_NUM_COL];

   // One slice per colour: decode, storage and readback
   for (genvar i = 0; i < `GOB_NUM_COL; i++) begin : g_col
      // Byte address of this colour's registers
      wire addr_t off_addr = `GOB_ADDR_OFF_RED + `GOB_ADDR_W'(i) * `GOB_REG_STRIDE;
      wire addr_t gain_addr = `GOB_ADDR_GAIN_RED + `GOB_ADDR_W'(i) * `GOB_REG_STRIDE;

      // Own-location hits
      assign hit_off[i] = addr_aligned & (paddr == off_addr);
      assign hit_gain[i] = addr_aligned & (paddr == gain_addr);

      // Load on own address or on the broadcast one
      assign load_off[i] = wr_fire & (hit_off[i] | hit_off_all);
      assign load_gain[i] = wr_fire & (hit_gain[i] | hit_gain_all);

      // Offset code storage
      always_ff @(posedge core_clk or posedge rst) begin
         if (rst) begin
            // Mid-scale after reset
            offset_ff[i] <= `GOB_OFF_RST;
         end else if (load_off[i]) begin
            // Last write wins, whichever location it used
            offset_ff[i] <= wr_byte;
         end
      end

      // Gain code storage
      always_ff @(posedge core_clk or posedge rst) begin
         if (rst) begin
            // Lowest gain after reset
            gain_ff[i] <= `GOB_GAIN_RST;
         end else if (load_gain[i]) begin
            // Last write wins, whichever location it used
            gain_ff[i] <= wr_byte;
         end
      end

      // Readback words, low byte only
      assign rd_off[i] = hit_off[i] ? {`GOB_CODE_PAD, offset_ff[i]} : `GOB_DATA_ZERO;
      assign rd_gain[i] = hit_gain[i] ? {`GOB_CODE_PAD, gain_ff[i]} : `GOB_DATA_ZERO;

      // Feed the selector
      assign cb.offset_code[i] = offset_ff[i];
      assign cb.gain_code[i] = gain_ff[i];
   end

   // Colour choice comes from same-clock logic, no synchroniser
   assign cb.colour_select = colour_select;

   // Picks the applied codes and works out the gain
   colour_channel_select u_sel (
      .cb(cb.chan)
   );

   // Status word: colour choice, applied gain, applied offset
   wire apb_data_t rd_status = hit_status ?
      {`GOB_STAT_PAD, colour_select, gain_out_ff, offset_out_ff} : `GOB_DATA_ZERO;

   // Any mapped location; broadcast ones read as zero
   wire logic addr_mapped = (|hit_off) | (|hit_gain) | hit_off_all | hit_gain_all | hit_status;

   // Combined read word
   wire apb_data_t nxt_prdata = rd_off[`GOB_IDX_RED] | rd_off[`GOB_IDX_GREEN] | rd_off[`GOB_IDX_BLUE] |
                                rd_gain[`GOB_IDX_RED] | rd_gain[`GOB_IDX_GREEN] | rd_gain[`GOB_IDX_BLUE] |
                                rd_status;

   // Ready rises for exactly the access cycle after each setup
   wire logic nxt_pready = setup_phase;
   // Unmapped or misaligned addresses answer with an error
   wire logic nxt_pslverr = setup_phase & ~addr_mapped;

   // APB answer registers
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         // Idle answer
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
      end else begin
         // Answer is prepared in the setup cycle
         pready_ff <= nxt_pready;
         pslverr_ff <= nxt_pslverr;
      end
   end

   // Read data, captured in setup and held through access
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         // Zero out of reset, held until the first setup
         prdata_ff <= `GOB_DATA_ZERO;
      end else if (setup_phase) begin
         // Writes and unmapped reads see zero
         prdata_ff <= pwrite ? `GOB_DATA_ZERO : nxt_prdata;
      end
   end

   // Applied channel values follow the selector one cycle later
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         // Red slot at reset values
         offset_out_ff <= `GOB_OFF_RST;
         gain_out_ff <= `GOB_GAIN_RST;
         gain_milli_ff <= `GOB_MILLI_W'(`GOB_GAIN_BASE_MILLI);
      end else begin
         // Selected colour values
         offset_out_ff <= cb.sel_offset;
         gain_out_ff <= cb.sel_gain;
         gain_milli_ff <= cb.gain_milli;
      end
   end

   // First-cycle marker for reset checks
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         // Set through reset
         first_ff <= 1'b1;
      end else begin
         // Cleared at the first edge
         first_ff <= 1'b0;
      end
   end

   // Outputs straight from flops
   assign pready = pready_ff;
   assign prdata = prdata_ff;
   assign pslverr = pslverr_ff;
   assign offset_code_out = offset_out_ff;
   assign gain_code_out = gain_out_ff;
   assign gain_milli_out = gain_milli_ff;

   // Checks, all on the core clock
   default clocking cb_chk @(posedge core_clk);
   endclocking
   default disable iff (rst);

   // Write completions to the broadcast locations
   sequence s_off_all_write;
      wr_fire && hit_off_all;
   endsequence

   sequence s_gain_all_write;
      wr_fire && hit_gain_all;
   endsequence

   // Write completion to the red offset location alone
   sequence s_red_off_write;
      wr_fire && hit_off[`GOB_IDX_RED];
   endsequence

   // Setup cycle of any transfer
   sequence s_setup;
      psel && !penable;
   endsequence

   // Read setup of the red offset location
   sequence s_red_off_read;
      psel && !penable && !pwrite && hit_off[`GOB_IDX_RED];
   endsequence

   // Setup of an unmapped or misaligned location
   sequence s_refused_setup;
      psel && !penable && !addr_mapped;
   endsequence

   // Write completion that no location takes
   sequence s_refused_write;
      wr_fire && !addr_mapped;
   endsequence

   // Write completion to the red gain location alone
   sequence s_red_gain_write;
      wr_fire && hit_gain[`GOB_IDX_RED];
   endsequence

   // Offsets come out of reset at mid-scale
   property p_offset_reset;
      first_ff |-> (offset_ff[`GOB_IDX_RED] == `GOB_OFF_RST) &&
                   (offset_ff[`GOB_IDX_GREEN] == `GOB_OFF_RST) &&
                   (offset_ff[`GOB_IDX_BLUE] == `GOB_OFF_RST) &&
                   (offset_code_out == `GOB_OFF_RST);
   endproperty
   a_offset_reset: assert property (p_offset_reset) else $error("offset not mid-scale after reset");

   // Gains come out of reset at zero
   property p_gain_reset;
      first_ff |-> (gain_ff[`GOB_IDX_RED] == `GOB_GAIN_RST) &&
                   (gain_ff[`GOB_IDX_GREEN] == `GOB_GAIN_RST) &&
                   (gain_ff[`GOB_IDX_BLUE] == `GOB_GAIN_RST) &&
                   (gain_code_out == `GOB_GAIN_RST);
   endproperty
   a_gain_reset: assert property (p_gain_reset) else $error("gain not zero after reset");

   // Blue choice drives the blue codes one cycle later
   property p_select_blue;
      (colour_select == COLOUR_BLUE) |=>
         (offset_code_out == $past(offset_ff[`GOB_IDX_BLUE])) &&
         (gain_code_out == $past(gain_ff[`GOB_IDX_BLUE]));
   endproperty
   a_select_blue: assert property (p_select_blue) else $error("blue codes not applied");

   // Green choice drives the green codes one cycle later
   property p_select_green;
      (colour_select == COLOUR_GREEN) |=>
         (offset_code_out == $past(offset_ff[`GOB_IDX_GREEN])) &&
         (gain_code_out == $past(gain_ff[`GOB_IDX_GREEN]));
   endproperty
   a_select_green: assert property (p_select_green) else $error("green codes not applied");

   // Offset broadcast lands in all three slots
   property p_off_broadcast;
      s_off_all_write |=>
         (offset_ff[`GOB_IDX_RED] == $past(wr_byte)) &&
         (offset_ff[`GOB_IDX_GREEN] == $past(wr_byte)) &&
         (offset_ff[`GOB_IDX_BLUE] == $past(wr_byte));
   endproperty
   a_off_broadcast: assert property (p_off_broadcast) else $error("offset broadcast missed a colour");

   // Gain broadcast lands in all three slots
   property p_gain_broadcast;
      s_gain_all_write |=>
         (gain_ff[`GOB_IDX_RED] == $past(wr_byte)) &&
         (gain_ff[`GOB_IDX_GREEN] == $past(wr_byte)) &&
         (gain_ff[`GOB_IDX_BLUE] == $past(wr_byte));
   endproperty
   a_gain_broadcast: assert property (p_gain_broadcast) else $error("gain broadcast missed a colour");

   // Applied gain follows the linear law of the applied code
   property p_gain_law;
      ##1 (gain_milli_out == `GOB_MILLI_W'(`GOB_GAIN_BASE_MILLI +
          (`GOB_PROD_W'($past(cb.sel_gain)) * `GOB_GAIN_SLOPE_MILLI) / `GOB_GAIN_FULL_SCALE));
   endproperty
   a_gain_law: assert property (p_gain_law) else $error("gain value off the linear law");

   // Single red write replaces red only, one to eight cycles after a broadcast
   property p_single_override;
      s_off_all_write ##[1:8] s_red_off_write |=>
         (offset_ff[`GOB_IDX_RED] == $past(wr_byte)) &&
         $stable(offset_ff[`GOB_IDX_GREEN]) &&
         $stable(offset_ff[`GOB_IDX_BLUE]);
   endproperty
   a_single_override: assert property (p_single_override) else $error("single write did not override");

   // Every setup is answered in the next cycle, for one cycle
   property p_apb_answer;
      s_setup |=> pready ##1 !pready;
   endproperty
   a_apb_answer: assert property (p_apb_answer) else $error("apb answer timing wrong");

   // Red choice, or the reserved value, drives the red codes one cycle later
   property p_select_red;
      (colour_select == COLOUR_RED || colour_select == COLOUR_RSVD) |=>
         (offset_code_out == $past(offset_ff[`GOB_IDX_RED])) &&
         (gain_code_out == $past(gain_ff[`GOB_IDX_RED]));
   endproperty
   a_select_red: assert property (p_select_red) else $error("red codes not applied");

   // Single red gain write replaces red only, shortly after a gain broadcast
   property p_gain_override;
      s_gain_all_write ##[1:8] s_red_gain_write |=>
         (gain_ff[`GOB_IDX_RED] == $past(wr_byte)) &&
         $stable(gain_ff[`GOB_IDX_GREEN]) &&
         $stable(gain_ff[`GOB_IDX_BLUE]);
   endproperty
   a_gain_override: assert property (p_gain_override) else $error("gain write did not override");

   // Red offset read answers with the stored code in the low byte
   property p_read_red_off;
      s_red_off_read |=> (prdata == {`GOB_CODE_PAD, $past(offset_ff[`GOB_IDX_RED])}) && !pslverr;
   endproperty
   a_read_red_off: assert property (p_read_red_off) else $error("red offset read data wrong");

   // Refused locations answer with an error beside ready and zero data
   property p_refused_error;
      s_refused_setup |=> pready && pslverr && (prdata == `GOB_DATA_ZERO);
   endproperty
   a_refused_error: assert property (p_refused_error) else $error("refused access not flagged");

   // Refused writes leave every stored code alone
   property p_refused_write;
      s_refused_write |=>
         $stable(offset_ff[`GOB_IDX_RED]) && $stable(offset_ff[`GOB_IDX_GREEN]) &&
         $stable(offset_ff[`GOB_IDX_BLUE]) && $stable(gain_ff[`GOB_IDX_RED]) &&
         $stable(gain_ff[`GOB_IDX_GREEN]) && $stable(gain_ff[`GOB_IDX_BLUE]);
   endproperty
   a_refused_write: assert property (p_refused_write) else $error("refused write changed a code");
endmodule

// ### design/gob_consts.svh
`ifndef GOB_CONSTS_SVH
`define GOB_CONSTS_SVH
// Widths
`define GOB_CODE_W 8
`define GOB_DATA_W 32
`define GOB_ADDR_W 8
`define GOB_MILLI_W 14
`define GOB_PROD_W 21
`define GOB_NUM_COL 3
// Colour slot indices
`define GOB_IDX_RED 0
`define GOB_IDX_GREEN 1
`define GOB_IDX_BLUE 2
// Reset values
`define GOB_OFF_RST 8'h80
`define GOB_GAIN_RST 8'h00
// Register byte addresses
`define GOB_ADDR_OFF_RED 8'h00
`define GOB_ADDR_OFF_ALL 8'h0c
`define GOB_ADDR_GAIN_RED 8'h10
`define GOB_ADDR_GAIN_ALL 8'h1c
`define GOB_ADDR_STATUS 8'h20
`define GOB_REG_STRIDE 8'h04
`define GOB_ALIGN_MASK 8'h03
// Gain law in thousandths: base + code * slope / full scale
`define GOB_GAIN_BASE_MILLI 21'h00030c
`define GOB_GAIN_SLOPE_MILLI 21'h001d92
`define GOB_GAIN_FULL_SCALE 21'h0000ff
// Zero fill above the status fields
`define GOB_STAT_PAD 14'h0000
`define GOB_DATA_ZERO 32'h00000000
`define GOB_CODE_PAD 24'h000000
`endif

// ### design/gob_pkg.sv
`include "gob_consts.svh"
package gob_pkg;
   // One colour code byte
   typedef logic [`GOB_CODE_W-1:0] code_t;
   // APB data and address
   typedef logic [`GOB_DATA_W-1:0] apb_data_t;
   typedef logic [`GOB_ADDR_W-1:0] addr_t;
   // Gain in thousandths
   typedef logic [`GOB_MILLI_W-1:0] gain_milli_t;
   // Colour selection; the last value is reserved
   typedef enum logic [1:0] {COLOUR_RED, COLOUR_GREEN, COLOUR_BLUE, COLOUR_RSVD} colour_t;
endpackage

// ### design/code_bus_if.sv
`timescale 1ns/1ps
`include "gob_consts.svh"
interface code_bus_if;
   import gob_pkg::*;
   code_t offset_code [`GOB_NUM_COL]; // Stored offset codes
   code_t gain_code [`GOB_NUM_COL]; // Stored gain codes
   colour_t colour_select; // Current colour choice
   code_t sel_offset; // Selected offset code
   code_t sel_gain; // Selected gain code
   gain_milli_t gain_milli; // Selected gain in thousandths
   // Register side
   modport regs (output offset_code, gain_code, colour_select, input sel_offset, sel_gain, gain_milli);
   // Channel selector side
   modport chan (input offset_code, gain_code, colour_select, output sel_offset, sel_gain, gain_milli);
endinterface

// ### design/colour_channel_select.sv
`timescale 1ns/1ps
`include "gob_consts.svh"
module colour_channel_select (
   code_bus_if.chan cb
);
   import gob_pkg::*;

   // Colour decode
   wire logic is_green = (cb.colour_select == COLOUR_GREEN);
   wire logic is_blue = (cb.colour_select == COLOUR_BLUE);

   // Offset pick; red also covers the reserved value
   assign cb.sel_offset = is_green ? cb.offset_code[`GOB_IDX_GREEN] :
                          is_blue ? cb.offset_code[`GOB_IDX_BLUE] :
                          cb.offset_code[`GOB_IDX_RED];
   // Gain pick, same selection
   assign cb.sel_gain = is_green ? cb.gain_code[`GOB_IDX_GREEN] :
                        is_blue ? cb.gain_code[`GOB_IDX_BLUE] :
                        cb.gain_code[`GOB_IDX_RED];

   // Code times slope, wide enough for the full code range
   wire logic [`GOB_PROD_W-1:0] gain_prod = `GOB_PROD_W'(cb.sel_gain) * `GOB_GAIN_SLOPE_MILLI;
   // Linear gain law, truncated to whole thousandths
   wire logic [`GOB_PROD_W-1:0] gain_sum = `GOB_GAIN_BASE_MILLI + gain_prod / `GOB_GAIN_FULL_SCALE;
   assign cb.gain_milli = gain_sum[`GOB_MILLI_W-1:0];
endmodule

// ### verif/gain_offset_register_bank_bench.sv
`timescale 1ns/1ps
module gain_offset_register_bank_bench;
   import gob_pkg::*;
   // Stimulus driven at the rising edge
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   addr_t paddr = 8'h00;
   apb_data_t pwdata = 32'h00000000;
   colour_t colour_select = COLOUR_RED;
   // Design outputs
   logic pready;
   apb_data_t prdata;
   logic pslverr;
   code_t offset_code_out;
   code_t gain_code_out;
   gain_milli_t gain_milli_out;
   // Scoreboard state
   int mismatches = 0;
   int total_checks = 0;
   integer seed = 32'h8d336598;
   code_t m_off [3];
   code_t m_gain [3];
   bit held = 1'b0; // Bus left selected for a back-to-back setup
   bit b2b = 1'b0; // Next transfer follows at once

   // 250 MHz clock
   always #2 core_clk = ~core_clk;

   gain_offset_register_bank u_dut (
      .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .colour_select(colour_select), .offset_code_out(offset_code_out),
      .gain_code_out(gain_code_out), .gain_milli_out(gain_milli_out)
   );

   // Compare one value and count it
   task chk(input string name, input apb_data_t exp, input apb_data_t got);
      total_checks++;
      if (got !== exp) begin
         $display("ERROR %s expected %h seen %h", name, exp, got);
         mismatches++;
      end
   endtask

   // One APB transfer; waits for pready with no bound and counts the wait cycles
   task apb(input addr_t a, input logic w, input apb_data_t d, output apb_data_t r, output logic err);
      int n;
      n = 0;
      if (!held) @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      // Wait for the answer however long it takes; the watchdog ends a hang
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1);
      // One access cycle is all the slave ever needs
      chk("pready wait", 32'h00000001, apb_data_t'(n));
      r = prdata;
      err = pslverr;
      penable <= 1'b0;
      held = b2b;
      if (!b2b) psel <= 1'b0;
   endtask

   // Read and compare data and error flag
   task rd_chk(input addr_t a, input apb_data_t exp, input logic exp_err);
      apb_data_t r;
      logic e;
      apb(a, 1'b0, 32'h00000000, r, e);
      chk($sformatf("read data %h", a), exp, r);
      chk($sformatf("read error %h", a), {31'h00000000, exp_err}, {31'h00000000, e});
   endtask

   // Write one slot (0..7 maps to 00..1c) and update the model
   task wr_model(input int slot, input apb_data_t d);
      apb_data_t r;
      logic e;
      apb(8'(slot * 4), 1'b1, d, r, e);
      chk("write error", 32'h00000000, {31'h00000000, e});
      for (int i = 0; i < 3; i++) begin
         if (slot == i || slot == 3) m_off[i] = d[7:0];
         if (slot == i + 4 || slot == 7) m_gain[i] = d[7:0];
      end
   endtask

   // Gain in thousandths from the gain law
   function apb_data_t exp_milli(input code_t c);
      return 32'h0000030c + ({24'h000000, c} * 32'h00001d92) / 32'h000000ff;
   endfunction

   // Read all six code registers back to back
   task check_regs();
      for (int i = 0; i < 3; i++) begin
         b2b = 1'b1;
         rd_chk(8'(i * 4), {24'h000000, m_off[i]}, 1'b0);
         b2b = (i < 2);
         rd_chk(8'(16 + i * 4), {24'h000000, m_gain[i]}, 1'b0);
      end
   endtask

   // Select a colour and compare the applied codes and status
   task check_out(input colour_t c);
      int k;
      k = (c == COLOUR_RSVD) ? 0 : int'(c);
      colour_select <= c;
      repeat (2) @(posedge core_clk);
      chk("offset out", {24'h000000, m_off[k]}, {24'h000000, offset_code_out});
      chk("gain out", {24'h000000, m_gain[k]}, {24'h000000, gain_code_out});
      chk("gain milli", exp_milli(m_gain[k]), {18'h00000, gain_milli_out});
      rd_chk(8'h20, {14'h0000, c, m_gain[k], m_off[k]}, 1'b0);
   endtask

   // Print the counts and the verdict, then stop
   task close_out();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // Watchdog against a hung handshake
   initial begin
      #200000;
      $display("ERROR watchdog expected finish seen timeout");
      mismatches++;
      close_out();
   end

   // Main sequence
   initial begin
      apb_data_t r;
      logic e;
      int slot;
      m_off = '{8'h80, 8'h80, 8'h80};
      m_gain = '{8'h00, 8'h00, 8'h00};
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      check_regs();
      check_out(COLOUR_RED);
      $display("test reset values done");
      wr_model(3, 32'hffffff5a);
      wr_model(7, 32'h000000c3);
      check_regs();
      rd_chk(8'h0c, 32'h00000000, 1'b0);
      rd_chk(8'h1c, 32'h00000000, 1'b0);
      $display("test broadcast done");
      // Single red writes right behind a broadcast, then a green offset and a blue gain write
      wr_model(3, 32'h000000a5);
      wr_model(0, 32'h00000022);
      wr_model(7, 32'h00000033);
      wr_model(4, 32'h00000044);
      wr_model(1, 32'h00000011);
      wr_model(6, 32'h000000ee);
      check_regs();
      $display("test override done");
      wr_model(4, 32'h000000ff);
      for (int c = 0; c < 4; c++) check_out(colour_t'(c));
      wr_model(4, 32'h00000000);
      check_out(COLOUR_RED);
      $display("test colour select done");
      // Unmapped and misaligned places answer with an error and change nothing
      rd_chk(8'h24, 32'h00000000, 1'b1);
      rd_chk(8'h02, 32'h00000000, 1'b1);
      apb(8'h05, 1'b1, 32'h00000077, r, e);
      chk("misaligned write error", 32'h00000001, {31'h00000000, e});
      apb(8'h20, 1'b1, 32'h00000077, r, e);
      chk("status write error", 32'h00000000, {31'h00000000, e});
      check_regs();
      $display("test refused access done");
      // Random writes over all eight slots with periodic readback
      for (int n = 0; n < 48; n++) begin
         slot = $unsigned($random(seed)) % 8;
         wr_model(slot, $random(seed));
         if (n % 8 == 7) begin
            check_regs();
            check_out(colour_t'($unsigned($random(seed)) % 4));
         end
      end
      $display("test random traffic done");
      // Reset again mid-run; every code goes back to its reset value
      @(posedge core_clk);
      rst <= 1'b1;
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      m_off = '{8'h80, 8'h80, 8'h80};
      m_gain = '{8'h00, 8'h00, 8'h00};
      check_regs();
      check_out(COLOUR_BLUE);
      $display("test mid-run reset done");
      close_out();
   end
endmodule
